// file: core/store_path_pkg.sv
// constants for the store path and six-bit control register bank
package store_path_pkg;
  localparam int W          = 18;  // store word width
  localparam int CW         = 6;   // control register width
  localparam int NCTL       = 32;  // control registers
  localparam int NES        = 32;  // external registers
  localparam int NLS        = 32;  // local registers
  localparam int NSRC       = 4;   // six-bit source fields
  localparam int NDST       = 4;   // six-bit destination fields
  localparam int NDSEL      = 4;   // generic destination-end selectors
  localparam int NSSEL      = 6;   // generic source-end selectors
  localparam int NSET       = 3;   // transform parameter sets

  // external register indices of the relocation pair
  localparam logic [4:0] STORE_BASE_ADDRESS = 5'h10;
  localparam logic [4:0] STORE_LENGTH_LIMIT = 5'h11;

  // bus selector placement in the control bank
  localparam logic [4:0] SEL_STORE_OUT = 5'h00;
  localparam logic [4:0] SEL_STORE_IN  = 5'h01;
  localparam logic [4:0] SEL_EXT_OUT   = 5'h02;
  localparam logic [4:0] SEL_EXT_IN    = 5'h03;
  localparam int         SEL_DST_BASE  = 4;
  localparam int         SEL_SRC_BASE  = 8;

  localparam logic [5:0]   LOCAL_LAST = 6'h1F;
  localparam logic [5:0]   PORT_LAST  = 6'h27;
  localparam logic [W-1:0] FULL_LEN   = 18'h3FFFF;
  localparam logic [W-1:0] ALL_ONES   = 18'h3FFFF;
  localparam logic [W-1:0] ZERO_WORD  = 18'h00000;
  localparam logic [CW-1:0] CTL_ONES  = 6'h3F;
  localparam logic [CW-1:0] CTL_ZERO  = 6'h00;
  localparam logic [4:0]   ROT_WRAP   = 5'h12;  // rotate amount modulo 18
  localparam logic         PAR_GOOD   = 1'b1;   // odd parity over word+bit

  localparam logic [1:0] XF_BYPASS  = 2'h0;
  localparam logic [1:0] FLD_ROTATE = 2'h0;
  localparam logic [1:0] FLD_MASK   = 2'h1;
  localparam logic [1:0] FLD_INDEX  = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FULL, ST_EXTRACT, ST_PENDING, ST_INSERT
  } store_state_e;
endpackage

// file: core/store_path_bus_control.sv
// store access path, output transform and six-bit control register bank
module store_path_bus_control
  import store_path_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      option_present_i,
  input  wire logic                      absolute_access_override_i,
  input  wire logic [NLS-1:0][W-1:0]     local_regs_i,
  input  wire logic [W-1:0]              mem_top_i,
  input  wire logic                      store_start_i,
  input  wire logic                      store_insert_i,
  output logic                           mem_read_o,
  output logic                           mem_write_o,
  output logic [W-1:0]                   mem_addr_o,
  output logic [W-1:0]                   mem_wdata_o,
  input  wire logic                      mem_rvalid_i,
  input  wire logic [W-1:0]              mem_rdata_i,
  input  wire logic                      mem_rparity_i,
  input  wire logic                      mem_wdone_i,
  output logic                           store_busy_o,
  output logic [W-1:0]                   store_in_bus_o,
  output logic [W-1:0]                   store_out_bus_o,
  input  wire logic                      store_word_gate_out_i,
  input  wire logic [1:0]                xform_sel_i,
  input  wire logic [NSET-1:0]           rmi_load_i,
  input  wire logic [1:0]                rmi_field_i,
  output logic                           ls_wr_en_o,
  output logic [4:0]                     ls_wr_idx_o,
  output logic [W-1:0]                   ls_wr_data_o,
  input  wire logic                      ext_reg_write_i,
  input  wire logic [W-1:0]              ext_wdata_i,
  input  wire logic                      ext_reg_read_i,
  input  wire logic [4:0]                ext_rd_src_i,
  output logic                           es_rd_en_o,
  output logic [4:0]                     es_rd_idx_o,
  output logic [W-1:0]                   es_rd_data_o,
  input  wire logic [NSRC-1:0]           ctl_src_en_i,
  input  wire logic [NSRC-1:0][4:0]      ctl_src_idx_i,
  input  wire logic [NSRC-1:0][CW-1:0]   ctl_src_data_i,
  input  wire logic [NDST-1:0][NCTL-1:0] ctl_dst_mask_i,
  output logic [NDST-1:0][CW-1:0]        ctl_dst_data_o,
  input  wire logic                      ctl_inc_i,
  input  wire logic                      ctl_dec_i,
  input  wire logic [4:0]                ctl_step_idx_i,
  output logic [NDSEL-1:0][4:0]          dst_sel_idx_o,
  output logic [NSSEL-1:0][4:0]          src_sel_idx_o,
  output logic [NSSEL-1:0]               src_sel_ones_o,
  input  wire logic                      fault_ack_i,
  output logic                           store_bounds_fault_o,
  output logic                           parity_fault_o
);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  function automatic logic [W-1:0] rot_mask_add_unit(
    input logic [W-1:0] w, input logic [4:0] rot,
    input logic [W-1:0] msk, input logic [W-1:0] idx);
    logic [4:0]     amt;
    logic [2*W-1:0] dbl;
    amt = (rot >= ROT_WRAP) ? 5'(rot - ROT_WRAP) : rot;
    dbl = {w, w} >> amt;
    return W'((dbl[W-1:0] & msk) + idx);
  endfunction

  logic [NCTL-1:0][CW-1:0] ctl_r;
  logic [NES-1:0][W-1:0]   es_r;
  logic [NSET-1:0][4:0]    rot_r;
  logic [NSET-1:0][W-1:0]  mask_r;
  logic [NSET-1:0][W-1:0]  idx_r;
  logic [W-1:0]            mod_r;
  store_state_e            state_r;

  // selector decode
  logic [CW-1:0] in_sel, out_sel, eout_sel, ein_sel;
  assign in_sel   = ctl_r[SEL_STORE_IN];
  assign out_sel  = ctl_r[SEL_STORE_OUT];
  assign eout_sel = ctl_r[SEL_EXT_OUT];
  assign ein_sel  = ctl_r[SEL_EXT_IN];

  always_comb begin
    if (in_sel <= LOCAL_LAST) begin
      store_in_bus_o = local_regs_i[in_sel[4:0]];
    end else if (in_sel <= PORT_LAST) begin
      store_in_bus_o = es_r[in_sel[4:0]];
    end else begin
      store_in_bus_o = ALL_ONES;
    end
  end

  always_comb begin
    for (int i = 0; i < NDSEL; i++) begin
      dst_sel_idx_o[i] = ctl_r[SEL_DST_BASE + i][4:0];
    end
    for (int i = 0; i < NSSEL; i++) begin
      src_sel_idx_o[i]  = ctl_r[SEL_SRC_BASE + i][4:0];
      src_sel_ones_o[i] = ctl_r[SEL_SRC_BASE + i][CW-1];
    end
  end

  // relocation and bounds
  logic [W-1:0] eff_base, eff_len, abs_addr;
  logic [W:0]   abs_sum, lim_sum;
  logic         viol;
  always_comb begin
    if (absolute_access_override_i || !option_present_i) begin
      eff_base = ZERO_WORD;
      eff_len  = FULL_LEN;
    end else begin
      eff_base = es_r[STORE_BASE_ADDRESS];
      eff_len  = es_r[STORE_LENGTH_LIMIT];
    end
    abs_sum  = {1'b0, eff_base} + {1'b0, store_in_bus_o};
    lim_sum  = {1'b0, eff_base} + {1'b0, eff_len};
    abs_addr = abs_sum[W-1:0];
    // a carry out means the range wrapped past the top
    viol = abs_sum[W] || (abs_sum > lim_sum)
        || (abs_addr > mem_top_i);
  end

  logic start_ok, insert_ok, par_bad;
  assign start_ok  = store_start_i && state_r == ST_IDLE;
  assign insert_ok = store_insert_i
                  && (state_r == ST_EXTRACT || state_r == ST_PENDING);
  // the extracted word is checked even when the insert came first
  assign par_bad   = mem_rvalid_i && (^mem_rdata_i ^ mem_rparity_i) != PAR_GOOD
                  && (state_r == ST_FULL || state_r == ST_EXTRACT
                      || state_r == ST_PENDING);
  assign store_busy_o = state_r != ST_IDLE;

  logic extract_valid_r;
  // state: start with insert in the same step is a full read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r         <= ST_IDLE;
      extract_valid_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          extract_valid_r <= 1'b0;
          if (store_start_i && !viol) begin
            state_r <= store_insert_i ? ST_FULL : ST_EXTRACT;
          end
        end
        ST_FULL: begin
          if (mem_rvalid_i) state_r <= ST_IDLE;
        end
        ST_EXTRACT: begin
          if (store_insert_i) state_r <= ST_PENDING;
          if (mem_rvalid_i) extract_valid_r <= 1'b1;
        end
        ST_PENDING: begin
          // insert waits until the extraction half has finished
          if (extract_valid_r || mem_rvalid_i) state_r <= ST_INSERT;
          if (mem_rvalid_i) extract_valid_r <= 1'b1;
        end
        ST_INSERT: begin
          if (mem_wdone_i) state_r <= ST_IDLE;
        end
      endcase
    end
  end

  logic [W-1:0] ins_data_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_read_o  <= 1'b0;
      mem_write_o <= 1'b0;
      mem_addr_o  <= ZERO_WORD;
      mem_wdata_o <= ZERO_WORD;
      ins_data_r  <= ZERO_WORD;
    end else begin
      mem_read_o  <= start_ok && !viol;
      mem_write_o <= 1'b0;
      if (start_ok && !viol) mem_addr_o <= abs_addr;
      if (insert_ok && state_r == ST_EXTRACT) ins_data_r <= store_in_bus_o;
      if (state_r == ST_PENDING && (extract_valid_r || mem_rvalid_i)) begin
        mem_write_o <= 1'b1;
        mem_wdata_o <= ins_data_r;
      end
    end
  end

  // output bus: held until the next store operation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_r <= ZERO_WORD;
    end else if (start_ok) begin
      mod_r <= viol ? ALL_ONES : ZERO_WORD;
    end else if (insert_ok && state_r == ST_EXTRACT) begin
      mod_r <= store_in_bus_o;
    end else if (mem_rvalid_i && (state_r == ST_FULL
                 || (state_r == ST_EXTRACT && !store_insert_i))) begin
      mod_r <= mem_rdata_i;
    end
  end
  assign store_out_bus_o = mod_r;

  // set wins over acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      store_bounds_fault_o <= 1'b0;
      parity_fault_o       <= 1'b0;
    end else begin
      store_bounds_fault_o <= (start_ok && viol)
                           || (store_bounds_fault_o && !fault_ack_i);
      parity_fault_o <= par_bad
                     || (parity_fault_o && !fault_ack_i);
    end
  end

  // transform parameter sets
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rot_r  <= '0;
      mask_r <= '0;
      idx_r  <= '0;
    end else begin
      for (int s = 0; s < NSET; s++) begin
        if (rmi_load_i[s]) begin
          if (rmi_field_i == FLD_ROTATE) rot_r[s] <= mod_r[4:0];
          if (rmi_field_i == FLD_MASK) mask_r[s] <= mod_r;
          if (rmi_field_i == FLD_INDEX) idx_r[s] <= mod_r;
        end
      end
    end
  end

  logic [W-1:0] gate_word;
  logic [1:0]   set_no;
  always_comb begin
    set_no    = 2'(xform_sel_i - 2'h1);
    gate_word = (xform_sel_i == XF_BYPASS) ? mod_r
              : rot_mask_add_unit(mod_r, rot_r[set_no], mask_r[set_no],
                                  idx_r[set_no]);
  end

  logic port_wr;
  assign port_wr = store_word_gate_out_i && out_sel > LOCAL_LAST
                && out_sel <= PORT_LAST;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ls_wr_en_o   <= 1'b0;
      ls_wr_idx_o  <= 5'h00;
      ls_wr_data_o <= ZERO_WORD;
    end else begin
      ls_wr_en_o <= store_word_gate_out_i && out_sel <= LOCAL_LAST;
      if (store_word_gate_out_i && out_sel <= LOCAL_LAST) begin
        ls_wr_idx_o  <= out_sel[4:0];
        ls_wr_data_o <= gate_word;
      end
    end
  end

  // external registers; simultaneous loads into one register OR together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      es_r <= '0;
    end else begin
      for (int e = 0; e < NES; e++) begin
        if ((ext_reg_write_i && ein_sel[4:0] == 5'(e))
            || (port_wr && out_sel[4:0] == 5'(e))) begin
          es_r[e] <= ((ext_reg_write_i && ein_sel[4:0] == 5'(e))
                      ? ext_wdata_i : ZERO_WORD)
                   | ((port_wr && out_sel[4:0] == 5'(e))
                      ? gate_word : ZERO_WORD);
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      es_rd_en_o   <= 1'b0;
      es_rd_idx_o  <= 5'h00;
      es_rd_data_o <= ZERO_WORD;
    end else begin
      es_rd_en_o <= ext_reg_read_i;
      if (ext_reg_read_i) begin
        es_rd_idx_o  <= eout_sel[4:0];
        es_rd_data_o <= eout_sel[CW-1] ? ZERO_WORD
                                       : es_r[ext_rd_src_i];
      end
    end
  end

  // control register bank; a load outranks an increment or decrement
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_r <= '0;
    end else begin
      for (int r = 0; r < NCTL; r++) begin
        logic [CW-1:0] acc;
        logic          hit;
        acc = CTL_ZERO;
        hit = 1'b0;
        for (int s = 0; s < NSRC; s++) begin
          if (ctl_src_en_i[s] && ctl_src_idx_i[s] == 5'(r)) begin
            acc = acc | ctl_src_data_i[s];
            hit = 1'b1;
          end
        end
        if (hit) begin
          ctl_r[r] <= acc;
        end else if (ctl_step_idx_i == 5'(r) && (ctl_inc_i ^ ctl_dec_i)) begin
          ctl_r[r] <= ctl_inc_i ? CW'(ctl_r[r] + 6'h01)
                                : CW'(ctl_r[r] - 6'h01);
        end
      end
    end
  end

  // an empty read mask delivers all ones, the identity of the AND
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_dst_data_o <= '0;
    end else begin
      for (int d = 0; d < NDST; d++) begin
        logic [CW-1:0] acc;
        acc = CTL_ONES;
        for (int r = 0; r < NCTL; r++) begin
          if (ctl_dst_mask_i[d][r]) acc = acc & ctl_r[r];
        end
        ctl_dst_data_o[d] <= acc;
      end
    end
  end

  viol_ones_a: assert property (start_ok && viol |=>
      store_out_bus_o == ALL_ONES && !mem_read_o && state_r == ST_IDLE)
    else $error("violation did not force ones or blocked access");
  bounds_flag_a: assert property (start_ok && viol |=>
      store_bounds_fault_o)
    else $error("bounds fault not flagged");
  disp_sum_a: assert property (start_ok && !viol |=>
      mem_read_o && mem_addr_o == $past(abs_addr))
    else $error("absolute address not base plus displacement");
  override_a: assert property (start_ok && absolute_access_override_i
      && store_in_bus_o <= mem_top_i |=>
      mem_read_o && mem_addr_o == $past(store_in_bus_o))
    else $error("override did not use zero base");
  no_option_a: assert property (start_ok && !option_present_i
      && store_in_bus_o <= mem_top_i |=>
      mem_read_o && mem_addr_o == $past(store_in_bus_o))
    else $error("absent option did not act as zero base");
  parity_flag_a: assert property (par_bad |=> parity_fault_o [*2]
      or (parity_fault_o ##1 $past(fault_ack_i)))
    else $error("parity failure not flagged");
  hold_word_a: assert property (!store_start_i && !store_insert_i
      && !mem_rvalid_i |=> $stable(store_out_bus_o))
    else $error("store output word changed without store operation");
  gate_null_a: assert property (store_word_gate_out_i
      && out_sel > PORT_LAST |=> !ls_wr_en_o && $stable(es_r))
    else $error("gate-out with selector above 39 transferred");
  step_wrap_a: assert property (ctl_inc_i && !ctl_dec_i
      && ctl_src_en_i == '0 |=>
      ctl_r[$past(ctl_step_idx_i)] == CW'($past(ctl_r[ctl_step_idx_i])
                                          + 6'h01))
    else $error("increment not modulo 64");
  ext_zero_a: assert property (ext_reg_read_i && eout_sel[CW-1] |=>
      es_rd_en_o && es_rd_data_o == ZERO_WORD)
    else $error("ext-out above 31 did not deliver zeros");
  in_ones_a: assert property (in_sel > PORT_LAST |->
      store_in_bus_o == ALL_ONES)
    else $error("store input bus not all ones");

  viol_seen_c: cover property (start_ok && viol);
  full_read_c: cover property (start_ok && store_insert_i && !viol
      ##[1:20] mem_rvalid_i);
  split_write_c: cover property (state_r == ST_PENDING ##[1:20] mem_write_o);
  rmi_gate_c: cover property (store_word_gate_out_i
      && xform_sel_i != XF_BYPASS && out_sel <= LOCAL_LAST);
endmodule

// file: test/store_mem_model.sv
// main store partner: fixed-latency word memory with odd parity
module store_mem_model
  import store_path_pkg::*;
#(
  parameter int LAT = 3
)
(
  input  wire logic         clk_i,
  input  wire logic         read_i,
  input  wire logic         write_i,
  input  wire logic [W-1:0] addr_i,
  input  wire logic [W-1:0] wdata_i,
  input  wire logic         bad_parity_i,
  output logic              rvalid_o,
  output logic [W-1:0]      rdata_o,
  output logic              rparity_o,
  output logic              wdone_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // only 256 words are kept, so higher addresses alias
  logic [W-1:0] mem [256];
  logic [7:0]   idx_r;
  logic         wr_r;
  int           cnt_r;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = {2'b10, i[7:0], ~i[7:0]};
    end
    rvalid_o = 1'b0;
    wdone_o = 1'b0;
    rdata_o = 18'h15555;
    rparity_o = 1'b0;
    cnt_r = 0;
    idx_r = 8'h00;
    wr_r = 1'b0;
  end
  always @(posedge clk_i) begin
    rvalid_o <= 1'b0;
    wdone_o <= 1'b0;
    // data lines keep moving outside the valid cycle, never hold a word
    rdata_o <= ~rdata_o;
    rparity_o <= ~rparity_o;
    if (read_i || write_i) begin
      idx_r <= addr_i[7:0];
      wr_r <= write_i;
      cnt_r <= LAT;
      if (write_i) begin
        mem[addr_i[7:0]] <= wdata_i;
      end
    end else if (cnt_r == 1) begin
      cnt_r <= 0;
      if (wr_r) begin
        wdone_o <= 1'b1;
      end else begin
        rvalid_o <= 1'b1;
        rdata_o <= mem[idx_r];
        rparity_o <= ~^mem[idx_r] ^ bad_parity_i;
      end
    end else if (cnt_r > 1) begin
      cnt_r <= cnt_r - 1;
    end
  end
endmodule

// file: test/store_path_bus_control_bench.sv
// self-checking bench for the store path and control register bank
module store_path_bus_control_bench
  import store_path_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, option_present_i, absolute_access_override_i;
  logic store_start_i, store_insert_i, mem_read_o, mem_write_o;
  logic mem_rvalid_i, mem_rparity_i, mem_wdone_i, store_busy_o;
  logic store_word_gate_out_i, ls_wr_en_o, ext_reg_write_i;
  logic ext_reg_read_i, es_rd_en_o, ctl_inc_i, ctl_dec_i, fault_ack_i;
  logic store_bounds_fault_o, parity_fault_o, bad_par;
  logic [NLS-1:0][W-1:0]     local_regs_i;
  logic [W-1:0]              mem_top_i, mem_addr_o, mem_wdata_o;
  logic [W-1:0]              mem_rdata_i, store_in_bus_o, store_out_bus_o;
  logic [W-1:0]              ls_wr_data_o, ext_wdata_i, es_rd_data_o, w;
  logic [1:0]                xform_sel_i, rmi_field_i;
  logic [NSET-1:0]           rmi_load_i;
  logic [4:0]                ls_wr_idx_o, ext_rd_src_i, es_rd_idx_o;
  logic [4:0]                ctl_step_idx_i;
  logic [NSRC-1:0]           ctl_src_en_i;
  logic [NSRC-1:0][4:0]      ctl_src_idx_i;
  logic [NSRC-1:0][CW-1:0]   ctl_src_data_i;
  logic [NDST-1:0][NCTL-1:0] ctl_dst_mask_i;
  logic [NDST-1:0][CW-1:0]   ctl_dst_data_o;
  logic [NDSEL-1:0][4:0]     dst_sel_idx_o;
  logic [NSSEL-1:0][4:0]     src_sel_idx_o;
  logic [NSSEL-1:0]          src_sel_ones_o;
  logic [W-1:0]              vals [3] = '{18'h2F0C4, 18'h1234F, 18'h3FFE9};
  int                        bad_count = 0;
  int                        n_compared = 0;
  int                        wr_cnt = 0;
  int                        n0;

  store_path_bus_control DUT (
    .clk_i, .rst_i, .option_present_i, .absolute_access_override_i,
    .local_regs_i, .mem_top_i, .store_start_i, .store_insert_i,
    .mem_read_o, .mem_write_o, .mem_addr_o, .mem_wdata_o, .mem_rvalid_i,
    .mem_rdata_i, .mem_rparity_i, .mem_wdone_i, .store_busy_o,
    .store_in_bus_o, .store_out_bus_o, .store_word_gate_out_i,
    .xform_sel_i, .rmi_load_i, .rmi_field_i, .ls_wr_en_o, .ls_wr_idx_o,
    .ls_wr_data_o, .ext_reg_write_i, .ext_wdata_i, .ext_reg_read_i,
    .ext_rd_src_i, .es_rd_en_o, .es_rd_idx_o, .es_rd_data_o,
    .ctl_src_en_i, .ctl_src_idx_i, .ctl_src_data_i, .ctl_dst_mask_i,
    .ctl_dst_data_o, .ctl_inc_i, .ctl_dec_i, .ctl_step_idx_i,
    .dst_sel_idx_o, .src_sel_idx_o, .src_sel_ones_o, .fault_ack_i,
    .store_bounds_fault_o, .parity_fault_o
  );
  store_mem_model #(.LAT(3)) mem_model (
    .clk_i(clk_i), .read_i(mem_read_o), .write_i(mem_write_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .bad_parity_i(bad_par),
    .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i),
    .rparity_o(mem_rparity_i), .wdone_o(mem_wdone_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (mem_write_o === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
    end
  end

  function automatic logic [W-1:0] pat(input logic [W-1:0] a);
    return {2'b10, a[7:0], ~a[7:0]};
  endfunction
  // reference transform; rotate amounts in the table stay below 18
  function automatic logic [W-1:0] xf(input logic [W-1:0] d,
                                      input logic [W-1:0] v);
    logic [W-1:0] r;
    r = (d >> v[4:0]) | (d << (W - v[4:0]));
    return (r & v) + v;
  endfunction
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // every pulse task except access ends with an idle edge so drivers never collide
  task automatic load_ctl(input logic [4:0] idx, input logic [5:0] val);
    ctl_src_en_i[0] <= 1'b1;
    ctl_src_idx_i[0] <= idx;
    ctl_src_data_i[0] <= val;
    tick;
    ctl_src_en_i[0] <= 1'b0;
    tick;
  endtask
  task automatic read_ctl(input logic [4:0] idx, input logic [5:0] exp);
    ctl_dst_mask_i[1] <= 32'h1 << idx;
    tick;
    chk({12'h000, ctl_dst_data_o[1]}, {12'h000, exp});
  endtask
  task automatic step(input logic inc, input logic dec);
    ctl_step_idx_i <= 5'h16;
    ctl_inc_i <= inc;
    ctl_dec_i <= dec;
    tick;
    ctl_inc_i <= 1'b0;
    ctl_dec_i <= 1'b0;
    tick;
  endtask
  task automatic ext_wr(input logic [5:0] idx, input logic [W-1:0] d);
    load_ctl(SEL_EXT_IN, idx);
    ext_wdata_i <= d;
    ext_reg_write_i <= 1'b1;
    tick;
    ext_reg_write_i <= 1'b0;
    tick;
  endtask
  task automatic ext_rd(input logic [4:0] src, input logic [5:0] dst,
                        input logic [W-1:0] exp);
    load_ctl(SEL_EXT_OUT, dst);
    ext_rd_src_i <= src;
    ext_reg_read_i <= 1'b1;
    tick;
    ext_reg_read_i <= 1'b0;
    chkb(es_rd_en_o, 1'b1);
    chk({13'h0000, es_rd_idx_o}, {13'h0000, dst[4:0]});
    chk(es_rd_data_o, exp);
    tick;
  endtask
  task automatic wait_idle;
    int i;
    i = 0;
    do begin
      tick;
      i++;
    end while (store_busy_o !== 1'b0 && i < 60);
    if (i >= 60) begin
      bad_count++;
      $display("[FAIL] t=%0t busy=%h exp=%h", $time, store_busy_o, 1'b0);
      give_verdict;
    end
  endtask
  task automatic access(input logic [W-1:0] disp, input logic full);
    local_regs_i[0] <= disp;
    store_start_i <= 1'b1;
    store_insert_i <= full;
    tick;
    store_start_i <= 1'b0;
    store_insert_i <= 1'b0;
  endtask
  task automatic read_ok(input logic [W-1:0] disp, input logic [W-1:0] a,
                         input logic [W-1:0] exp);
    access(disp, 1'b1);
    chkb(mem_read_o, 1'b1);
    chk(mem_addr_o, a);
    wait_idle;
    chk(store_out_bus_o, exp);
  endtask
  task automatic read_bad(input logic [W-1:0] disp, input logic full);
    access(disp, full);
    chkb(store_bounds_fault_o, 1'b1);
    chk(store_out_bus_o, ALL_ONES);
    chkb(mem_read_o, 1'b0);
    wait_idle;
    chkb(store_bounds_fault_o, 1'b1);
    fault_ack_i <= 1'b1;
    tick;
    fault_ack_i <= 1'b0;
    chkb(store_bounds_fault_o, 1'b0);
    tick;
  endtask
  task automatic split(input logic [W-1:0] disp, input logic [W-1:0] d);
    access(disp, 1'b0);
    chkb(mem_read_o, 1'b1);
    tick;
    local_regs_i[0] <= d;
    store_insert_i <= 1'b1;
    tick;
    store_insert_i <= 1'b0;
    wait_idle;
    chk(store_out_bus_o, d);
  endtask
  task automatic gate(input logic [5:0] sel, input logic [1:0] xs,
                      input logic en, input logic [W-1:0] exp);
    load_ctl(SEL_STORE_OUT, sel);
    xform_sel_i <= xs;
    store_word_gate_out_i <= 1'b1;
    tick;
    store_word_gate_out_i <= 1'b0;
    chkb(ls_wr_en_o, en);
    if (en) begin
      chk(ls_wr_data_o, exp);
      chk({13'h0000, ls_wr_idx_o}, {13'h0000, sel[4:0]});
    end
    tick;
  endtask

  initial begin
    {rst_i, option_present_i, absolute_access_override_i} = 3'b110;
    {store_start_i, store_insert_i, store_word_gate_out_i} = 3'b000;
    {ext_reg_write_i, ext_reg_read_i, ctl_inc_i, ctl_dec_i} = 4'h0;
    {fault_ack_i, bad_par, xform_sel_i, rmi_field_i} = 6'h00;
    {rmi_load_i, ext_rd_src_i, ctl_step_idx_i} = '0;
    {ctl_src_en_i, ctl_src_idx_i, ctl_src_data_i} = '0;
    local_regs_i = '0;
    ctl_dst_mask_i = '0;
    mem_top_i = 18'h3FFFF;
    ext_wdata_i = 18'h00000;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    tick;
    chk(store_out_bus_o, ZERO_WORD);
    chkb(store_busy_o, 1'b0);
    chkb(store_bounds_fault_o, 1'b0);
    chk({13'h0000, dst_sel_idx_o[0]}, 18'h00000);
    done("reset");
    ctl_src_en_i <= 4'b0011;
    ctl_src_idx_i[0] <= 5'h14;
    ctl_src_idx_i[1] <= 5'h14;
    ctl_src_data_i[0] <= 6'h05;
    ctl_src_data_i[1] <= 6'h18;
    tick;
    ctl_src_en_i <= 4'b0000;
    tick;
    read_ctl(5'h14, 6'h1D);
    load_ctl(5'h15, 6'h0F);
    ctl_dst_mask_i[1] <= 32'h0030_0000;
    tick;
    chk({12'h000, ctl_dst_data_o[1]}, 18'h0000D);
    load_ctl(5'h16, 6'h3F);
    step(1'b1, 1'b0);
    read_ctl(5'h16, 6'h00);
    step(1'b0, 1'b1);
    read_ctl(5'h16, 6'h3F);
    done("control bank");
    load_ctl(5'h04, 6'h25);
    chk({13'h0000, dst_sel_idx_o[0]}, 18'h00005);
    load_ctl(5'h08, 6'h21);
    chkb(src_sel_ones_o[0], 1'b1);
    load_ctl(5'h08, 6'h07);
    chkb(src_sel_ones_o[0], 1'b0);
    chk({13'h0000, src_sel_idx_o[0]}, 18'h00007);
    done("selectors");
    ext_wr(6'h27, 18'h01234);
    load_ctl(SEL_STORE_IN, 6'h27);
    chk(store_in_bus_o, 18'h01234);
    load_ctl(SEL_STORE_IN, 6'h28);
    chk(store_in_bus_o, ALL_ONES);
    local_regs_i[9] <= 18'h0ABCD;
    load_ctl(SEL_STORE_IN, 6'h09);
    chk(store_in_bus_o, 18'h0ABCD);
    ext_rd(5'h07, 6'h23, ZERO_WORD);
    ext_rd(5'h07, 6'h03, 18'h01234);
    load_ctl(SEL_STORE_IN, 6'h00);
    done("external and store input");
    ext_wr({1'b0, STORE_BASE_ADDRESS}, 18'h00100);
    ext_wr({1'b0, STORE_LENGTH_LIMIT}, 18'h0000F);
    read_ok(18'h0000F, 18'h0010F, pat(18'h0010F));
    read_bad(18'h00010, 1'b1);
    absolute_access_override_i <= 1'b1;
    read_ok(18'h00010, 18'h00010, pat(18'h00010));
    absolute_access_override_i <= 1'b0;
    option_present_i <= 1'b0;
    read_ok(18'h00020, 18'h00020, pat(18'h00020));
    option_present_i <= 1'b1;
    mem_top_i <= 18'h00104;
    read_bad(18'h00005, 1'b1);
    mem_top_i <= 18'h3FFFF;
    read_ok(18'h00002, 18'h00102, pat(18'h00102));
    n0 = wr_cnt;
    read_bad(18'h00010, 1'b0);
    chk(18'(wr_cnt - n0), 18'h00000);
    done("relocation");
    split(18'h00003, 18'h2AAAA);
    chk(18'(wr_cnt - n0), 18'h00001);
    read_ok(18'h00003, 18'h00103, 18'h2AAAA);
    for (int s = 0; s < 3; s++) begin
      split(18'h00000, vals[s]);
      for (int f = 0; f < 3; f++) begin
        rmi_load_i <= 3'(1 << s);
        rmi_field_i <= 2'(f);
        tick;
        rmi_load_i <= 3'b000;
        tick;
      end
    end
    w = pat(18'h00105);
    read_ok(18'h00005, 18'h00105, w);
    gate(6'h06, XF_BYPASS, 1'b1, w);
    for (int s = 0; s < 3; s++) begin
      gate(6'h06, 2'(s + 1), 1'b1, xf(w, vals[s]));
    end
    gate(6'h06, XF_BYPASS, 1'b1, w);
    gate(6'h21, XF_BYPASS, 1'b0, w);
    ext_rd(5'h01, 6'h02, w);
    gate(6'h28, XF_BYPASS, 1'b0, w);
    done("split and transform");
    bad_par <= 1'b1;
    access(18'h00006, 1'b1);
    wait_idle;
    bad_par <= 1'b0;
    chkb(parity_fault_o, 1'b1);
    tick;
    chkb(parity_fault_o, 1'b1);
    fault_ack_i <= 1'b1;
    tick;
    fault_ack_i <= 1'b0;
    chkb(parity_fault_o, 1'b0);
    bad_par <= 1'b1;
    split(18'h00007, 18'h00011);
    bad_par <= 1'b0;
    chkb(parity_fault_o, 1'b1);
    done("parity");
    give_verdict;
  end
endmodule
